// ==== rtl/osf_defines.svh ====
// Constants for the oversampling average filter
`ifndef OSF_DEFINES_SVH
`define OSF_DEFINES_SVH
`define OSF_CHANNELS        8
`define OSF_SAMPLE_W        14
`define OSF_ACC_W           20
`define OSF_CODE_W          3
`define OSF_OS_NONE         3'h0
`define OSF_OS_INVALID      3'h7
`define OSF_FIFO_DEPTH      32
`define OSF_CLK_PERIOD_NS   100
`define OSF_SAMPLE_PERIOD_NS 5000
`define OSF_SAMPLE_CYCLES   ((`OSF_SAMPLE_PERIOD_NS + `OSF_CLK_PERIOD_NS - 1) / `OSF_CLK_PERIOD_NS)
`define OSF_TIMER_W         7
`define OSF_SYNC_W          7
`endif

// ==== rtl/osf_pkg.sv ====
// Types for the oversampling average filter
`include "osf_defines.svh"
package osf_pkg;
  typedef logic [`OSF_CHANNELS-1:0][`OSF_SAMPLE_W-1:0] chan_words_t;
  typedef logic [`OSF_CHANNELS-1:0][`OSF_ACC_W-1:0]    chan_sums_t;
  typedef struct packed {
    logic [`OSF_CODE_W-1:0] ratio_code;
    chan_words_t            chan;
  } result_t;
  typedef struct packed {
    logic                   start_a;
    logic                   start_b;
    logic [`OSF_CODE_W-1:0] os_code;
    logic                   range_high;
    logic                   ref_internal;
  } pins_t;
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_GAP, S_PUSH} filt_state_t;
endpackage : osf_pkg

// ==== rtl/oversampling_average_filter.sv ====
// Oversampling average filter with decimation, result FIFO and pin configuration
// Behaviour
// - Decode oversample select; code 111 rejected
// - Output rate falls inversely with ratio
// - First group sample on conversion-start rising edge
// - Remaining samples triggered by internal timer
// - Average all samples of a group
// - One 14-bit word per channel per group
// - Range pin sets gain for all channels
// - Reference select pin chooses reference source
// - Reference buffer amplifier always enabled
// - High selects internal; low powers bandgap down
`timescale 1ns/1ps
`default_nettype none
`include "osf_defines.svh"

module result_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      level_ff;
  logic             out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             push;
  logic             pop;
  logic             load_out;
  logic             mem_rd;
  logic             bypass;
  logic             mem_wr;

  assign push        = i_in_valid && o_in_ready;
  assign pop         = out_valid_ff && i_out_ready;
  assign load_out    = !out_valid_ff || pop;
  assign mem_rd      = load_out && (level_ff != '0);
  assign bypass      = load_out && (level_ff == '0) && push; // Empty array: straight to output
  assign mem_wr      = push && !bypass;
  // Output stage counts toward capacity, so exactly DEPTH words fit in all
  assign o_in_ready  = ((level_ff + {{AW{1'b0}}, out_valid_ff}) != DEPTH[AW:0]);
  assign o_out_valid = out_valid_ff;
  assign o_out_data  = out_data_ff;

  // Storage has no reset; only pointers, fill level and output valid are reset
  always_ff @(posedge i_clk) begin
    if (mem_wr) begin
      mem[wr_ptr_ff] <= i_in_data;
    end
  end

  // Registered output stage keeps array read paths off the drain side
  always_ff @(posedge i_clk) begin
    if (mem_rd) begin
      out_data_ff <= mem[rd_ptr_ff];
    end else if (bypass) begin
      out_data_ff <= i_in_data;
    end
  end

  // Output valid refills whenever the stage empties or is popped
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      out_valid_ff <= 1'b0;
    end else if (load_out) begin
      out_valid_ff <= mem_rd || push;
    end
  end

  // Pointers and fill level of the array
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      level_ff  <= '0;
    end else begin
      if (mem_wr) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (mem_rd) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (mem_wr && !mem_rd) level_ff <= level_ff + 1'b1;
      else if (mem_rd && !mem_wr) level_ff <= level_ff - 1'b1;
    end
  end
endmodule : result_fifo

module oversampling_average_filter
  import osf_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Host pins
  input  wire logic        i_conv_start_group_a,
  input  wire logic        i_conv_start_group_b,
  input  wire logic [2:0]  i_oversample_select,
  input  wire logic        i_range_select,
  input  wire logic        i_reference_source_select,
  // Converter core
  output logic             o_sample_strobe,
  input  wire logic        i_sample_valid,
  input  wire chan_words_t i_sample_data,
  // Analog control
  output logic             o_gain_high_range,
  output logic             o_ref_internal_enable,
  output logic             o_bandgap_power_down,
  output logic             o_ref_buffer_enable,
  output logic             o_reference_io_pin_oe,
  // Result stream
  output logic             o_result_valid,
  input  wire logic        i_result_ready,
  output result_t          o_result,
  output logic             o_busy
);
  localparam logic [`OSF_TIMER_W-1:0] SAMPLE_CYCLES = `OSF_TIMER_W'(`OSF_SAMPLE_CYCLES);

  pins_t                      pins_raw;
  logic [`OSF_SYNC_W-1:0]     s1_ff, s2_ff, s3_ff, clean_ff;
  pins_t                      pins;
  logic                       both_high_ff;
  logic                       start_edge;
  filt_state_t                state_ff;
  logic [2:0]                 shift_ff;
  logic [6:0]                 count_ff;
  logic [`OSF_TIMER_W-1:0]    timer_ff;
  chan_sums_t                 sum_ff;
  result_t                    push_data;
  logic                       push_valid;
  logic                       push_ready;
  logic                       out_valid;
  result_t                    out_data;
  logic                       last_sample;

  assign pins_raw = '{start_a: i_conv_start_group_a, start_b: i_conv_start_group_b,
                      os_code: i_oversample_select, range_high: i_range_select,
                      ref_internal: i_reference_source_select};

  // Three-stage pin synchroniser; a change counts once stages two and three agree
  genvar gb;
  generate
    for (gb = 0; gb < `OSF_SYNC_W; gb++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          s1_ff[gb]    <= 1'b0;
          s2_ff[gb]    <= 1'b0;
          s3_ff[gb]    <= 1'b0;
          clean_ff[gb] <= 1'b0;
        end else begin
          s1_ff[gb] <= pins_raw[gb];
          s2_ff[gb] <= s1_ff[gb];
          s3_ff[gb] <= s2_ff[gb];
          if (s2_ff[gb] == s3_ff[gb]) clean_ff[gb] <= s3_ff[gb];
        end
      end
    end
  endgenerate
  assign pins = pins_t'(clean_ff);

  // Group start is the rise of both start lines being high
  always_ff @(posedge i_clk) begin
    if (i_reset) both_high_ff <= 1'b0;
    else         both_high_ff <= pins.start_a && pins.start_b;
  end
  assign start_edge  = pins.start_a && pins.start_b && !both_high_ff;
  assign last_sample = (count_ff + 7'h01) == (7'h01 << shift_ff);

  // Group sequencer; starts while busy are dropped, so the rate cannot overrun
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_ff <= S_IDLE;
      shift_ff <= 3'h0;
      count_ff <= 7'h00;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (start_edge && pins.os_code != `OSF_OS_INVALID) begin
            state_ff <= S_WAIT;
            shift_ff <= pins.os_code;
            count_ff <= 7'h00;
          end
        end
        S_WAIT: begin
          if (i_sample_valid) begin
            count_ff <= count_ff + 7'h01;
            state_ff <= last_sample ? S_PUSH : S_GAP;
          end
        end
        S_GAP: begin
          if (timer_ff == '0) state_ff <= S_WAIT;
        end
        S_PUSH: begin
          if (push_ready) state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // Sample timer spaces conversions at the full converter rate
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      timer_ff        <= '0;
      o_sample_strobe <= 1'b0;
    end else begin
      o_sample_strobe <= 1'b0;
      if (timer_ff != '0) timer_ff <= timer_ff - 1'b1;
      if (state_ff == S_IDLE && start_edge && pins.os_code != `OSF_OS_INVALID) begin
        o_sample_strobe <= 1'b1;
        timer_ff        <= SAMPLE_CYCLES - 1'b1;
      end else if (state_ff == S_GAP && timer_ff == '0) begin
        o_sample_strobe <= 1'b1;
        timer_ff        <= SAMPLE_CYCLES - 1'b1;
      end
    end
  end

  // Per-channel accumulators and mean by arithmetic shift
  genvar gc;
  generate
    for (gc = 0; gc < `OSF_CHANNELS; gc++) begin : g_chan
      logic [`OSF_ACC_W-1:0] mean;
      always_ff @(posedge i_clk) begin
        if (i_reset || (state_ff == S_IDLE)) begin
          sum_ff[gc] <= '0;
        end else if (state_ff == S_WAIT && i_sample_valid) begin
          sum_ff[gc] <= sum_ff[gc] + `OSF_ACC_W'(signed'(i_sample_data[gc]));
        end
      end
      assign mean = `OSF_ACC_W'($signed(sum_ff[gc]) >>> shift_ff);
      assign push_data.chan[gc] = mean[`OSF_SAMPLE_W-1:0];
    end
  endgenerate
  assign push_data.ratio_code = shift_ff;
  assign push_valid = (state_ff == S_PUSH);

  result_fifo #(
    .WIDTH ($bits(result_t)),
    .DEPTH (`OSF_FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   (push_data),
    .o_out_valid (out_valid),
    .i_out_ready (i_result_ready),
    .o_out_data  (out_data)
  );
  assign o_result_valid = out_valid;
  assign o_result       = out_data;

  // Analog controls follow the filtered pins; buffer amplifier never switched off
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_gain_high_range     <= 1'b0;
      o_ref_internal_enable <= 1'b0;
      o_bandgap_power_down  <= 1'b1;
      o_reference_io_pin_oe <= 1'b0;
      o_ref_buffer_enable   <= 1'b1;
      o_busy                <= 1'b0;
    end else begin
      o_gain_high_range     <= pins.range_high;
      o_ref_internal_enable <= pins.ref_internal;
      o_bandgap_power_down  <= !pins.ref_internal;
      o_reference_io_pin_oe <= pins.ref_internal;
      o_ref_buffer_enable   <= 1'b1;
      o_busy                <= (state_ff != S_IDLE);
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [`OSF_TIMER_W-1:0] since_ff;
  always_ff @(posedge i_clk) begin
    if (i_reset || o_sample_strobe) since_ff <= '0;
    else if (since_ff != '1) since_ff <= since_ff + 1'b1;
  end
  a_invalid_code_blocked: assert property (state_ff == S_IDLE && pins.os_code == `OSF_OS_INVALID
    |=> state_ff == S_IDLE) else $error("invalid ratio started a group");
  a_strobe_spacing_min: assert property (o_sample_strobe && $past(state_ff) != S_IDLE
    |-> since_ff >= SAMPLE_CYCLES - 1'b1) else $error("strobes too close");
  a_first_on_edge: assert property (state_ff == S_IDLE && start_edge && pins.os_code != `OSF_OS_INVALID
    |=> o_sample_strobe && state_ff == S_WAIT) else $error("no first strobe on edge");
  a_internal_strobe_gap: assert property (state_ff == S_GAP && timer_ff == '0
    |=> o_sample_strobe ##0 state_ff == S_WAIT) else $error("internal strobe missing");
  a_push_count_exact: assert property ($rose(push_valid)
    |-> count_ff == (7'h01 << shift_ff)) else $error("result before all samples");
  a_one_word_group: assert property (push_valid && push_ready
    |=> !push_valid [*2]) else $error("more than one word per group");
  a_range_follows_pin: assert property (##1 o_gain_high_range == $past(pins.range_high))
    else $error("gain does not follow range");
  a_ref_select_pair: assert property (o_bandgap_power_down == !o_ref_internal_enable
    && o_ref_buffer_enable) else $error("reference controls inconsistent");
  c_no_oversample: cover property (state_ff == S_PUSH && shift_ff == `OSF_OS_NONE);
  c_ratio_64: cover property (state_ff == S_PUSH && shift_ff == 3'h6);
  c_fifo_full: cover property (push_valid && !push_ready);
  c_start_while_busy: cover property (state_ff != S_IDLE && start_edge);
endmodule : oversampling_average_filter
`default_nettype wire

// ==== sim/conv_core_model.sv ====
// Behavioural converter core answering each sample strobe after a set delay
`timescale 1ns/1ps
`default_nettype none
module conv_core_model
  import osf_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Strobe side
  input  wire logic        i_strobe,
  input  wire logic [7:0]  i_delay,
  input  wire chan_words_t i_next,
  // Sample side
  output logic             o_valid,
  output chan_words_t      o_data
);
  int          cnt;
  chan_words_t held;
  // One answer per strobe; delay of at least one cycle
  always @(posedge i_clk) begin
    o_valid <= 1'b0;
    if (i_reset) begin
      cnt <= 0;
    end else if (i_strobe) begin
      cnt <= i_delay;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      o_valid <= 1'b1;
      held <= i_next;
    end
  end
  // Stale data is inverted so a late read never matches by chance
  assign o_data = o_valid ? held : ~held;
endmodule : conv_core_model
`default_nettype wire

// ==== sim/oversampling_average_filter_tb.sv ====
// Self-checking testbench for the oversampling average filter
`timescale 1ns/1ps
`default_nettype none
module oversampling_average_filter_tb
  import osf_pkg::*;
;
  logic        clk = 0, rst = 1, sa = 0, sb = 0, rng = 0, rsel = 0, rdy = 0, hold = 0;
  logic        sv, rv, bsy, stb, g, ri, bp, be, oe;
  logic [2:0]  os = 3'h0, cc = 3'h0;
  logic [7:0]  dly = 8'h03;
  logic [31:0] rs = 32'hca66;
  chan_words_t nd = '0, sd;
  result_t     res, e;
  result_t     q[$];
  int          error_cnt = 0, checks = 0, strb = 0, nv = 0, n = 1, cyc = 0, last = 0, lim;
  int          sum[8] = '{default: 0};
  always #50 clk = ~clk;
  oversampling_average_filter u_dut (.i_clk(clk), .i_reset(rst), .i_conv_start_group_a(sa),
    .i_conv_start_group_b(sb), .i_oversample_select(os), .i_range_select(rng),
    .i_reference_source_select(rsel), .o_sample_strobe(stb), .i_sample_valid(sv),
    .i_sample_data(sd), .o_gain_high_range(g), .o_ref_internal_enable(ri),
    .o_bandgap_power_down(bp), .o_ref_buffer_enable(be), .o_reference_io_pin_oe(oe),
    .o_result_valid(rv), .i_result_ready(rdy), .o_result(res), .o_busy(bsy));
  conv_core_model u_core (.i_clk(clk), .i_reset(rst), .i_strobe(stb), .i_delay(dly),
    .i_next(nd), .o_valid(sv), .o_data(sd));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  task automatic conclude();
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // Random data and ready, changed away from the sampling edge
  always @(negedge clk) begin
    rs = xs(rs);
    nd = 112'({4{rs}});
    rdy <= hold ? 1'b0 : rs[0];
  end
  // Reference model: sums per channel, floor mean, queued until popped
  always @(posedge clk) begin
    cyc++;
    lim = (dly + 4 > 50) ? dly + 4 : 50;
    if (stb) begin
      if (nv > 0) chk(cyc - last >= 50 && cyc - last <= lim, 1);
      last = cyc;
      strb++;
    end
    if (sv) begin
      for (int i = 0; i < 8; i++) sum[i] += $signed(sd[i]);
      nv++;
      if (nv == n) begin
        e.ratio_code = cc;
        for (int i = 0; i < 8; i++) e.chan[i] = 14'(sum[i] >>> cc);
        q.push_back(e);
        sum = '{default: 0};
        nv = 0;
      end
    end
    if (rv === 1'b1 && rdy) begin
      if (q.size() == 0) chk(0, 1);
      else begin
        e = q.pop_front();
        chk(res.ratio_code, e.ratio_code);
        for (int i = 0; i < 8; i++) chk(res.chan[i], e.chan[i]);
      end
    end
  end
  task automatic pulse();
    sa = 1;
    sb = 1;
    repeat (8) @(negedge clk);
    sa = 0;
    sb = 0;
  endtask : pulse
  // One group; a second start during a long group must be ignored
  task automatic grp(input logic [2:0] c, input bit w);
    int s0;
    int k;
    os = c;
    repeat (5) @(negedge clk);
    if (c != 3'h7) begin
      cc = c;
      n = 1 << c;
    end
    s0 = strb;
    pulse();
    if (c == 3'h7) chk(strb, s0);
    else if (w) begin
      if (c > 1) begin
        repeat (20) @(negedge clk);
        pulse();
      end
      k = 0;
      while (bsy !== 1'b0 && k < 5000) begin
        @(negedge clk);
        k++;
      end
      chk(bsy, 0);
      chk(strb - s0, 1 << c);
    end
  endtask : grp
  initial begin
    int k;
    int s1;
    repeat (10) @(negedge clk);
    rst = 0;
    repeat (6) @(negedge clk);
    for (int m = 0; m < 4; m++) begin
      rng = m[0];
      rsel = m[1];
      repeat (6) @(negedge clk);
      chk(g, rng);
      chk(ri, rsel);
      chk(bp, !rsel);
      chk(oe, rsel);
      chk(be, 1);
    end
    for (int c = 0; c < 8; c++) begin
      dly = (c == 2) ? 8'h3c : 8'h03;
      grp(3'(c), 1);
    end
    // Drain leftovers first so exactly 32 stalled words fill the store
    k = 0;
    while (q.size() > 0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    // Fill the result store with the drain stalled, then two more groups
    hold = 1;
    for (int m = 0; m < 32; m++) grp(3'h0, 1);
    grp(3'h0, 0);
    repeat (20) @(negedge clk);
    chk(bsy, 1);
    s1 = strb;
    grp(3'h0, 0);
    chk(strb, s1);
    hold = 0;
    k = 0;
    while (q.size() > 0 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    repeat (4) @(negedge clk);
    chk(rv, 0);
    chk(bsy, 0);
    conclude();
  end
  // Watchdog sized well above the longest expected run
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule : oversampling_average_filter_tb
`default_nettype wire
